// [logic/irqrs_defs.svh]
// constants of the raw interrupt status and output control block
`ifndef IRQRS_DEFS_SVH
`define IRQRS_DEFS_SVH
// register indexes (byte address is four times the index)
`define IRQRS_IDX_PIN_HI16     16'h1991
`define IRQRS_IDX_PIN_TOP8     16'h1992
`define IRQRS_IDX_FIFO_NE      16'h1995
`define IRQRS_IDX_FIFO_FULL    16'h1996
`define IRQRS_IDX_FIFO_WM      16'h1997
`define IRQRS_IDX_DMA_DONE     16'h1998
`define IRQRS_IDX_DSP_ACT      16'h199D
`define IRQRS_IDX_CTRL1        16'h1A80
`define IRQRS_IDX_CTRL2        16'h1A82
`define IRQRS_IDX_COMBINED     16'h1AA0
// field positions
`define IRQRS_BIT_MASK         11
`define IRQRS_BIT_POL          10
`define IRQRS_BIT_DRV          9
`define IRQRS_BIT_STS2         1
`define IRQRS_BIT_STS1         0
// reset values
`define IRQRS_RST_MASK         1'b0
`define IRQRS_RST_POL          1'b1
`define IRQRS_RST_DRV          1'b0
`endif

// [logic/irqrs_pkg.sv]
// types of the raw interrupt status and output control block
`default_nettype none
package irqrs_pkg;
   typedef enum logic [1:0] {
      IRQRS_DRV_CMOS  = 2'h0,
      IRQRS_DRV_OPEN  = 2'h1
   } irqrs_drv_t;
   typedef logic [31:0] irqrs_word_t;
endpackage
`default_nettype wire

// [logic/irqrs_top.sv]
// raw interrupt status registers and interrupt output stage, APB slave
// register map, word index (byte address is index * 4)
//   0x1991  pin 17..32 levels, bits 15:0
//   0x1992  pin 33..40 levels, bits 7:0
//   0x1995  event fifo not-empty, bits 7:0
//   0x1996  event fifo full, bits 7:0
//   0x1997  event fifo watermark reached, bits 7:0
//   0x1998  dsp core dma done, bits 6:0
//   0x199D  dsp core activity, bits 6:0
//   0x1A80  first output control: mask 11, polarity 10, driver 9
//   0x1A82  second output control: mask 11
//   0x1AA0  combined status: second 1, first 0
// other indexes answer with pslverr and read 0
//
// bus timing: zero wait states, pready tied high
//   setup   read data captured from the live sources
//   access  prdata and pslverr valid, writes land at this edge
//   after   prdata holds until the next read setup
// interrupt pins follow events and mask changes one edge later
`timescale 1ns/1ns
`default_nettype none
`include "irqrs_defs.svh"
module irqrs_top #(
   parameter int NPINS   = 24,
   parameter int NFIFO   = 8,
   parameter int NDSP    = 7,
   parameter int NEV1    = 16,
   parameter int NEV2    = 16
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output irqrs_pkg::irqrs_word_t     prdata,
   output logic                       pslverr,
   input  wire logic [NPINS-1:0]      pinLevel,
   input  wire logic [NPINS-1:0]      pinIsGpInput,
   input  wire logic [NPINS-1:0]      dsp_owned_pin,
   input  wire logic [NFIFO-1:0]      fifoNonEmpty,
   input  wire logic [NFIFO-1:0]      fifoFull,
   input  wire logic [NFIFO-1:0]      fifoWatermark,
   input  wire logic [NDSP-1:0]       dmaDone,
   input  wire logic [NDSP-1:0]       dspActive,
   input  wire logic [NEV1-1:0]       first_channel_event,
   input  wire logic [NEV2-1:0]       second_channel_event,
   output logic                       irq1Out,
   output logic                       irq1Oe,
   output logic                       irq2Out,
   output logic                       irq2Oe
);
   import irqrs_pkg::*;

   // control bits
   logic       firstMask_r;
   logic       secondMask_r;
   logic       polarity_r;
   logic       driver_r;
   irqrs_word_t rdata_r;

   // decode: printed offsets are indexes, byte address is index * 4
   wire        access    = psel & penable;
   wire        wrStrobe  = access & pwrite;
   wire [15:0] regIdx    = paddr[17:2];
   wire        aligned   = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0);
   wire        selCtrl1  = aligned && (regIdx == `IRQRS_IDX_CTRL1);
   wire        selCtrl2  = aligned && (regIdx == `IRQRS_IDX_CTRL2);

   // non-gp or dsp-owned pins read 0 rather than stray levels
   wire [NPINS-1:0] pinFlags;
   for (genvar g = 0; g < NPINS; g++) begin : gen_pin
      assign pinFlags[g] = pinLevel[g] & pinIsGpInput[g] & ~dsp_owned_pin[g];
   end

   wire [31:0]      pinBus   = 32'(pinFlags);

   // combined status per channel; events arrive already masked per source
   wire first_channel_combined  = |first_channel_event;
   wire second_channel_combined = |second_channel_event;

   wire [2:0]  ctrl1Field = {firstMask_r, polarity_r, driver_r};
   wire [31:0] ctrl1Word  = 32'(ctrl1Field) << `IRQRS_BIT_DRV;
   wire [31:0] ctrl2Word  = 32'(secondMask_r) << `IRQRS_BIT_MASK;
   wire [1:0]  combField  = {second_channel_combined, first_channel_combined};

   // one select per raw register, control selects are above
   wire selPinHi    = aligned && (regIdx == `IRQRS_IDX_PIN_HI16);
   wire selPinTop   = aligned && (regIdx == `IRQRS_IDX_PIN_TOP8);
   wire selFifoNe   = aligned && (regIdx == `IRQRS_IDX_FIFO_NE);
   wire selFifoFull = aligned && (regIdx == `IRQRS_IDX_FIFO_FULL);
   wire selFifoWm   = aligned && (regIdx == `IRQRS_IDX_FIFO_WM);
   wire selDmaDone  = aligned && (regIdx == `IRQRS_IDX_DMA_DONE);
   wire selDspAct   = aligned && (regIdx == `IRQRS_IDX_DSP_ACT);
   // combined status select
   wire selComb     = aligned && (regIdx == `IRQRS_IDX_COMBINED);

   // gated read words, zero-extended to the bus width
   wire [31:0] pinHiWord;
   wire [31:0] pinTopWord;
   wire [31:0] fifoNeWord;
   wire [31:0] fifoFullWord;
   wire [31:0] fifoWmWord;
   wire [31:0] dmaDoneWord;
   wire [31:0] dspActWord;
   wire [31:0] ctrl1RdWord;
   wire [31:0] ctrl2RdWord;
   wire [31:0] combWord;

   // raw words are live views, sampled at each read setup
   irqrs_raw_word #(.WIDTH(16)) u_pinHi (
      .sel  (selPinHi),
      .raw  (pinBus[15:0]),
      .word (pinHiWord)
   );

   irqrs_raw_word #(.WIDTH(8)) u_pinTop (
      .sel  (selPinTop),
      .raw  (pinBus[23:16]),
      .word (pinTopWord)
   );

   irqrs_raw_word #(.WIDTH(NFIFO)) u_fifoNe (
      .sel  (selFifoNe),
      .raw  (fifoNonEmpty),
      .word (fifoNeWord)
   );

   irqrs_raw_word #(.WIDTH(NFIFO)) u_fifoFull (
      .sel  (selFifoFull),
      .raw  (fifoFull),
      .word (fifoFullWord)
   );

   irqrs_raw_word #(.WIDTH(NFIFO)) u_fifoWm (
      .sel  (selFifoWm),
      .raw  (fifoWatermark),
      .word (fifoWmWord)
   );

   irqrs_raw_word #(.WIDTH(NDSP)) u_dmaDone (
      .sel  (selDmaDone),
      .raw  (dmaDone),
      .word (dmaDoneWord)
   );

   irqrs_raw_word #(.WIDTH(NDSP)) u_dspAct (
      .sel  (selDspAct),
      .raw  (dspActive),
      .word (dspActWord)
   );

   irqrs_raw_word #(.WIDTH(32)) u_ctrl1Rd (
      .sel  (selCtrl1),
      .raw  (ctrl1Word),
      .word (ctrl1RdWord)
   );

   irqrs_raw_word #(.WIDTH(32)) u_ctrl2Rd (
      .sel  (selCtrl2),
      .raw  (ctrl2Word),
      .word (ctrl2RdWord)
   );

   irqrs_raw_word #(.WIDTH(2)) u_comb (
      .sel  (selComb),
      .raw  (combField),
      .word (combWord)
   );

   // and-or mux: with nothing selected the bus reads 0
   wire [31:0] rdMux = pinHiWord
                     | pinTopWord
                     | fifoNeWord
                     | fifoFullWord
                     | fifoWmWord
                     | dmaDoneWord
                     | dspActWord
                     | ctrl1RdWord
                     | ctrl2RdWord
                     | combWord;

   // hit: any mapped register selected
   wire hit = selPinHi
            | selPinTop
            | selFifoNe
            | selFifoFull
            | selFifoWm
            | selDmaDone
            | selDspAct
            | selCtrl1
            | selCtrl2
            | selComb;

   // zero-wait slave; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;
   assign prdata  = rdata_r;

   // captured in setup so the word stands through the access phase
   wire rdLoad = psel && !penable && !pwrite;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0;
      end else if (rdLoad) begin
         rdata_r <= rdMux;
      end
   end

   // only control registers take writes; raw status ignores them
   // a write to a raw register is accepted without error
   wire wrCtrl1 = wrStrobe && selCtrl1;
   wire wrCtrl2 = wrStrobe && selCtrl2;

   // first output control: mask, polarity, driver
   irqrs_ctrl_bit #(.RESET(`IRQRS_RST_MASK)) u_firstMask (
      .clk   (clk),
      .rst_n (rst_n),
      .wen   (wrCtrl1),
      .d     (pwdata[`IRQRS_BIT_MASK]),
      .q     (firstMask_r)
   );

   irqrs_ctrl_bit #(.RESET(`IRQRS_RST_POL)) u_polarity (
      .clk   (clk),
      .rst_n (rst_n),
      .wen   (wrCtrl1),
      .d     (pwdata[`IRQRS_BIT_POL]),
      .q     (polarity_r)
   );

   irqrs_ctrl_bit #(.RESET(`IRQRS_RST_DRV)) u_driver (
      .clk   (clk),
      .rst_n (rst_n),
      .wen   (wrCtrl1),
      .d     (pwdata[`IRQRS_BIT_DRV]),
      .q     (driver_r)
   );

   // second output control: mask only
   irqrs_ctrl_bit #(.RESET(`IRQRS_RST_MASK)) u_secondMask (
      .clk   (clk),
      .rst_n (rst_n),
      .wen   (wrCtrl2),
      .d     (pwdata[`IRQRS_BIT_MASK]),
      .q     (secondMask_r)
   );

   // both pins share polarity and driver style, each has its own mask
   irqrs_out_stage u_out1 (
      .clk       (clk),
      .rst_n     (rst_n),
      .combined  (first_channel_combined),
      .mask      (firstMask_r),
      .polarity  (polarity_r),
      .openDrain (driver_r),
      .pinOut    (irq1Out),
      .pinOe     (irq1Oe)
   );

   irqrs_out_stage u_out2 (
      .clk       (clk),
      .rst_n     (rst_n),
      .combined  (second_channel_combined),
      .mask      (secondMask_r),
      .polarity  (polarity_r),
      .openDrain (driver_r),
      .pinOut    (irq2Out),
      .pinOe     (irq2Oe)
   );

endmodule // irqrs_top

// zero-extends one raw status field onto the bus, gated by its select
module irqrs_raw_word #(
   parameter int WIDTH = 8
) (
   input  wire logic             sel,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [31:0]      word
);
   localparam int BUSW = 32;

   // no latch: a read always shows the current condition
   wire [BUSW-1:0] wide = BUSW'(raw);
   assign word = sel ? wide : 32'h0;
endmodule // irqrs_raw_word

// one software-writable control bit with its own reset value
module irqrs_ctrl_bit #(
   parameter logic RESET = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic wen,
   input  wire logic d,
   output logic      q
);
   logic val_r;
   logic val_nxt;

   // hold unless this register is written in its access cycle
   assign val_nxt = wen ? d : val_r;

   // reset value differs per bit: polarity idles inverted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         val_r <= RESET;
      end else begin
         val_r <= val_nxt;
      end
   end
   assign q = val_r;
endmodule // irqrs_ctrl_bit

// one interrupt pin: registered activity, polarity and driver style
// the pin lags the combined status by one edge; that buys a
// glitch-free pin while event inputs settle
module irqrs_out_stage (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic combined,
   input  wire logic mask,
   input  wire logic polarity,
   input  wire logic openDrain,
   output logic      pinOut,
   output logic      pinOe
);
   logic active_r;
   logic active_nxt;
   logic level;

   // a masked channel keeps its status but stays quiet on the pin
   assign active_nxt = combined & ~mask;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
      end
   end

   // inverted polarity puts the idle pin high, matching a pull-up
   assign level  = active_r ^ polarity;
   assign pinOut = level;

   // open drain drives only the asserted level and releases otherwise
   assign pinOe  = openDrain ? active_r : 1'b1;
endmodule // irqrs_out_stage
`default_nettype wire

// [tb/irqrs_asserts.sv]
// checker of interrupt pins and control readback
`timescale 1ns/1ns
`default_nettype none
`include "irqrs_defs.svh"
module irqrs_chk #(parameter int NEV1 = 16, parameter int NEV2 = 16) (
   input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] paddr, pwdata,
   input wire irqrs_pkg::irqrs_word_t prdata,
   input wire logic [NEV1-1:0] first_channel_event,
   input wire logic [NEV2-1:0] second_channel_event,
   input wire logic irq1Out, irq1Oe, irq2Out, irq2Oe
);
   import irqrs_pkg::*;
   logic m1_r, pol_r, drv_r, m2_r;
   wire acc = psel && penable;
   wire [15:0] idx = paddr[17:2];
   wire ok = paddr[1:0] == 2'h0 && paddr[31:18] == 14'h0;
   wire c1 = ok && idx == `IRQRS_IDX_CTRL1;
   wire c2 = ok && idx == `IRQRS_IDX_CTRL2;
   wire a1 = |first_channel_event && !m1_r;
   wire a2 = |second_channel_event && !m2_r;
   // shadow of the control bits, updated at the write's access edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) {m1_r, pol_r, drv_r, m2_r} <= 4'h4;
      else if (acc && pwrite && c1) {m1_r, pol_r, drv_r} <= pwdata[11:9];
      else if (acc && pwrite && c2) m2_r <= pwdata[11];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rd(logic hit); acc && !pwrite && hit; endsequence
   a_irq1_level: assert property ($stable(pol_r) |-> irq1Out == ($past(a1) ^ pol_r))
      else $error("irq1 level wrong");
   a_irq2_level: assert property ($stable(pol_r) |-> irq2Out == ($past(a2) ^ pol_r))
      else $error("irq2 level wrong");
   a_irq1_enable: assert property ($stable(drv_r) |-> irq1Oe == (!drv_r || $past(a1)))
      else $error("irq1 enable wrong");
   a_irq2_enable: assert property ($stable(drv_r) |-> irq2Oe == (!drv_r || $past(a2)))
      else $error("irq2 enable wrong");
   a_combined_read: assert property (rd(ok && idx == `IRQRS_IDX_COMBINED) |-> prdata ==
      {30'h0, $past(|second_channel_event), $past(|first_channel_event)}) else $error("combined");
   a_ctrl1_read: assert property (rd(c1) |-> prdata == {20'h0, $past({m1_r, pol_r, drv_r}), 9'h0})
      else $error("ctrl1 readback");
   a_ctrl2_read: assert property (rd(c2) |-> prdata == {20'h0, $past(m2_r), 11'h0})
      else $error("ctrl2 readback");
   a_unmapped_err: assert property (rd(ok && idx == 16'h1993) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access");
   a_ready_high: assert property (acc |-> pready) else $error("no ready");
endmodule // irqrs_chk
bind irqrs_top irqrs_chk #(.NEV1(NEV1), .NEV2(NEV2)) u_chk (.*);
`default_nettype wire

// [tb/irqrs_host.sv]
// host model: resolves the interrupt pins
`timescale 1ns/1ns
`default_nettype none
module irqrs_host (
   input wire logic out1, oe1, out2, oe2, pol,
   output logic seen1, seen2
);
   // released pin is pulled to the inactive level, never left at its last value
   assign seen1 = (oe1 ? out1 : pol) ^ pol;
   assign seen2 = (oe2 ? out2 : pol) ^ pol;
endmodule // irqrs_host
`default_nettype wire

// [tb/irqrs_tb_top.sv]
// random bench of the raw status and interrupt output block
`timescale 1ns/1ns
`default_nettype none
`include "irqrs_defs.svh"
module irqrs_tb_top;
   import irqrs_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [31:0] paddr = 0, pwdata = 0, d, ev;
   irqrs_word_t prdata, rd;
   logic [23:0] pinLevel = 0, pinIsGpInput = 0, dsp_owned_pin = 0;
   logic [7:0] fifoNonEmpty = 0, fifoFull = 0, fifoWatermark = 0;
   logic [6:0] dmaDone = 0, dspActive = 0;
   logic [15:0] first_channel_event = 0, second_channel_event = 0;
   logic irq1Out, irq1Oe, irq2Out, irq2Oe, s1, s2, m2 = 0;
   logic [2:0] c1 = 3'h2;
   logic [127:0] r;
   int failures = 0, n_compared = 0, seed = 12, cyc = 0;
   logic [15:0] idx [11] = '{`IRQRS_IDX_PIN_HI16, `IRQRS_IDX_PIN_TOP8, `IRQRS_IDX_FIFO_NE,
      `IRQRS_IDX_FIFO_FULL, `IRQRS_IDX_FIFO_WM, `IRQRS_IDX_DMA_DONE, `IRQRS_IDX_DSP_ACT,
      `IRQRS_IDX_CTRL1, `IRQRS_IDX_CTRL2, `IRQRS_IDX_COMBINED, 16'h1993};
   irqrs_top u_dut (.*);
   irqrs_host u_host (.out1(irq1Out), .oe1(irq1Oe), .out2(irq2Out), .oe2(irq2Oe),
      .pol(c1[1]), .seen1(s1), .seen2(s2));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin failures++; give_verdict; end
   end
   task give_verdict;
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
      psel <= 1; pwrite <= w; paddr <= {14'h0, a, 2'h0}; pwdata <= wd;
      @(posedge clk) penable <= 1;
      @(posedge clk) while (pready !== 1'b1) @(posedge clk);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk);
   endtask
   function logic [31:0] exp_of(input logic [15:0] a);
      logic [23:0] p;
      p = pinLevel & pinIsGpInput & ~dsp_owned_pin;
      case (a)
         `IRQRS_IDX_PIN_HI16: return {16'h0, p[15:0]};
         `IRQRS_IDX_PIN_TOP8: return {24'h0, p[23:16]};
         `IRQRS_IDX_FIFO_NE: return {24'h0, fifoNonEmpty};
         `IRQRS_IDX_FIFO_FULL: return {24'h0, fifoFull};
         `IRQRS_IDX_FIFO_WM: return {24'h0, fifoWatermark};
         `IRQRS_IDX_DMA_DONE: return {25'h0, dmaDone};
         `IRQRS_IDX_DSP_ACT: return {25'h0, dspActive};
         `IRQRS_IDX_CTRL1: return {20'h0, c1, 9'h0};
         `IRQRS_IDX_CTRL2: return {20'h0, m2, 11'h0};
         `IRQRS_IDX_COMBINED: return {30'h0, |ev[15:0], |ev[31:16]};
         default: return 32'h0;
      endcase
   endfunction
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         r = {$random(seed), $random(seed), $random(seed), $random(seed)};
         {pinLevel, pinIsGpInput, dsp_owned_pin, fifoNonEmpty, fifoFull, fifoWatermark,
            dmaDone, dspActive} <= r[109:0];
         // zero, single-bit and random event patterns
         ev = i[1:0] == 2'h0 ? 32'h0 : i[0] ? 32'h1 << i[4:0] : $random(seed);
         {first_channel_event, second_channel_event} <= ev;
         @(posedge clk);
         foreach (idx[k]) begin
            apb(0, idx[k], 0);
            chk(rd, exp_of(idx[k]));
            chk(err, idx[k] == 16'h1993);
         end
         d = $random(seed); apb(1, `IRQRS_IDX_CTRL1, d); c1 = d[11:9];
         d = $random(seed); apb(1, `IRQRS_IDX_CTRL2, d); m2 = d[11];
         apb(1, idx[i % 7], $random(seed));
         repeat (2) @(posedge clk);
         chk(s1, |ev[31:16] && !c1[2]);
         chk(s2, |ev[15:0] && !m2);
         chk(irq1Oe, !c1[0] || s1);
      end
      give_verdict;
   end
endmodule // irqrs_tb_top
`default_nettype wire
